// >>> slcr_regs.vh
// Register offsets, field positions, reset values and codes of the serial link control bank.
`ifndef SLCR_REGS_VH
`define SLCR_REGS_VH
// Register indices; each register owns one aligned word whose byte address is four times its index.
`define SLCR_LINK_ENABLE_OFF 10'h200
`define SLCR_LINK_MODE_OFF 10'h201
`define SLCR_SOFT_SYNC_OFF 10'h203
`define SLCR_LINK_CONTROL_OFF 10'h204
`define SLCR_LINK_TEST_OFF 10'h205
`define SLCR_LINK_ID_OFF 10'h206
`define SLCR_LINK_ENABLE_RST 8'h01
`define SLCR_LINK_MODE_RST 8'h02
`define SLCR_SOFT_SYNC_RST 8'h01
`define SLCR_LINK_CONTROL_RST 8'h03
`define SLCR_LINK_TEST_RST 8'h00
`define SLCR_LINK_ID_RST 8'h00
`define SLCR_CTRL_MASK 8'h1F
`define SLCR_TEST_MASK 8'h1F
`define SLCR_ID_MASK 8'hFE
`define SLCR_REG_MSB 7
`define SLCR_BIT_SCR 0
`define SLCR_BIT_FMT 1
`define SLCR_SYNC_LO 2
`define SLCR_SYNC_HI 3
`define SLCR_BIT_UPPER 4
`define SLCR_SYNC_SE 2'h0
`define SLCR_SYNC_MARKER 2'h1
`define SLCR_SYNC_SOFT 2'h2
`define SLCR_T_NORMAL 5'h00
`define SLCR_T_PRBS7 5'h01
`define SLCR_T_PRBS15 5'h02
`define SLCR_T_PRBS23 5'h03
`define SLCR_T_RAMP 5'h04
`define SLCR_T_TRANSPORT 5'h05
`define SLCR_T_D215 5'h06
`define SLCR_T_K285 5'h07
`define SLCR_T_ILA 5'h08
`define SLCR_T_RPAT 5'h09
`define SLCR_T_LOW 5'h0A
`define SLCR_T_HIGH 5'h0B
`define SLCR_T_PRBS9 5'h0D
`define SLCR_T_PRBS31 5'h0E
`define SLCR_T_CLOCK 5'h0F
`define SLCR_T_K287 5'h10
`define SLCR_CLOCK_PATTERN 16'h00FF
`define SLCR_LANES_LOWER 8'h0F
`define SLCR_LANES_UPPER 8'hF0
`define SLCR_RESP_OKAY 2'h0
`define SLCR_RESP_SLVERR 2'h2
`endif

// >>> slcr_serial_link_control_regs.v
// AXI4-Lite register bank steering lane map, sync source, sample format, scrambler, test pattern and ILA identifier.
module slcr_serial_link_control_regs #(
    parameter ADDR_W = 12
) (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire single_ended_sync_pin,
    input wire marker_input_pin,
    input wire link_is_64b66b,
    output reg link_run_q,
    output reg [7:0] lane_enable_a_q,
    output reg [7:0] lane_enable_b_q,
    output reg sync_request_q,
    output reg marker_pin_receive_enable_q,
    output reg sample_format_q,
    output reg scramble_active_q,
    output reg [4:0] pattern_select_q,
    output reg hold_low_q,
    output reg hold_high_q,
    output reg [15:0] clock_pattern_q,
    output reg [7:0] ila_id_a_q,
    output reg [7:0] ila_id_b_q,
    output reg [7:0] link_mode_select_q
);
`include "slcr_regs.vh"

    // Software-visible storage.
    reg [7:0] link_enable_reg_q;
    reg [7:0] soft_sync_reg_q;
    reg [7:0] link_control_q;
    reg [7:0] link_test_control_q;
    reg [7:0] link_identifier_q;
    reg [7:0] link_mode_reg_q;
    // Write address and data latches so either may arrive first.
    reg aw_held_q;
    reg w_held_q;
    reg [ADDR_W-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    // Pin synchronisers; stage 1 is read only by stage 2.
    reg se_sync1_q, se_sync2_q, mk_sync1_q, mk_sync2_q;

    wire [1:0] sync_source = link_control_q[`SLCR_SYNC_HI:`SLCR_SYNC_LO];
    wire upper_lanes = link_control_q[`SLCR_BIT_UPPER];
    wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    wire [4:0] test_code = link_test_control_q[4:0];

    // Register index of a byte address; each register owns one aligned word.
    // The low two address bits only pick a byte inside that word, so they are dropped.
    function [ADDR_W-3:0] reg_index;
        input [ADDR_W-1:0] a;
        begin
            reg_index = a[ADDR_W-1:2];
        end
    endfunction

    // True when the address names a mapped register; anything else answers with an error.
    function is_mapped;
        input [ADDR_W-1:0] a;
        begin
            case (reg_index(a))
                `SLCR_LINK_ENABLE_OFF, `SLCR_LINK_MODE_OFF, `SLCR_SOFT_SYNC_OFF: is_mapped = 1'b1;
                `SLCR_LINK_CONTROL_OFF, `SLCR_LINK_TEST_OFF, `SLCR_LINK_ID_OFF: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // True when a write hits the register at the given index with its low byte strobe set.
    function hits;
        input [ADDR_W-1:0] a;
        input [3:0] strb;
        input [ADDR_W-3:0] idx;
        begin
            hits = (reg_index(a) == idx) && strb[0];
        end
    endfunction

    // Read word: the addressed register in the low byte, the upper bytes zero.
    function [31:0] read_word;
        input [ADDR_W-1:0] a;
        begin
            case (reg_index(a))
                `SLCR_LINK_ENABLE_OFF: read_word = {24'h000000, link_enable_reg_q};
                `SLCR_LINK_MODE_OFF: read_word = {24'h000000, link_mode_reg_q};
                `SLCR_SOFT_SYNC_OFF: read_word = {24'h000000, soft_sync_reg_q};
                `SLCR_LINK_CONTROL_OFF: read_word = {24'h000000, link_control_q};
                `SLCR_LINK_TEST_OFF: read_word = {24'h000000, link_test_control_q};
                `SLCR_LINK_ID_OFF: read_word = {24'h000000, link_identifier_q};
                default: read_word = 32'h00000000;
            endcase
        end
    endfunction

    // Write channel: accept address and data independently, respond once both are held.
    // Only the low byte of each word holds a register; the other strobes write nothing.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SLCR_RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= {ADDR_W{1'b0}};
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            link_enable_reg_q <= `SLCR_LINK_ENABLE_RST;
            link_mode_reg_q <= `SLCR_LINK_MODE_RST;
            soft_sync_reg_q <= `SLCR_SOFT_SYNC_RST;
            link_control_q <= `SLCR_LINK_CONTROL_RST;
            link_test_control_q <= `SLCR_LINK_TEST_RST;
            link_identifier_q <= `SLCR_LINK_ID_RST;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held_q && !s_axi_awready;
            s_axi_wready <= !w_held_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // The response waits for both halves, so a late data beat never meets a stale address.
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr_q) ? `SLCR_RESP_OKAY : `SLCR_RESP_SLVERR;
                if (hits(aw_addr_q, w_strb_q, `SLCR_LINK_ENABLE_OFF)) begin
                    link_enable_reg_q <= w_data_q[`SLCR_REG_MSB:0];
                end
                if (hits(aw_addr_q, w_strb_q, `SLCR_LINK_MODE_OFF)) begin
                    link_mode_reg_q <= w_data_q[`SLCR_REG_MSB:0];
                end
                if (hits(aw_addr_q, w_strb_q, `SLCR_SOFT_SYNC_OFF)) begin
                    soft_sync_reg_q <= w_data_q[`SLCR_REG_MSB:0];
                end
                if (hits(aw_addr_q, w_strb_q, `SLCR_LINK_CONTROL_OFF)) begin
                    link_control_q <= w_data_q[`SLCR_REG_MSB:0] & `SLCR_CTRL_MASK;
                end
                // Writes while the link runs are taken as written; software keeps them out.
                if (hits(aw_addr_q, w_strb_q, `SLCR_LINK_TEST_OFF)) begin
                    link_test_control_q <= w_data_q[`SLCR_REG_MSB:0] & `SLCR_TEST_MASK;
                end
                if (hits(aw_addr_q, w_strb_q, `SLCR_LINK_ID_OFF)) begin
                    link_identifier_q <= w_data_q[`SLCR_REG_MSB:0] & `SLCR_ID_MASK;
                end
            end
        end
    end

    // Read channel: one read at a time, data registered with the valid.
    // Ready idles as a pulse train; a master that holds arvalid is taken at its next high.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SLCR_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 : 1'b0;
            if (!s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_word(s_axi_araddr);
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `SLCR_RESP_OKAY : `SLCR_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b0;
            end
        end
    end

    // Pin inputs cross into this clock through two flops each.
    // Flops reset to the idle high level of these active-low pins, so reset raises no false request.
    always @(posedge aclk) begin
        if (!aresetn) begin
            se_sync1_q <= 1'b1;
            se_sync2_q <= 1'b1;
            mk_sync1_q <= 1'b1;
            mk_sync2_q <= 1'b1;
        end else if (clk_en) begin
            se_sync1_q <= single_ended_sync_pin;
            se_sync2_q <= se_sync1_q;
            mk_sync1_q <= marker_input_pin;
            mk_sync2_q <= mk_sync1_q;
        end
    end

    // Link-side controls, all registered; a disabled link zeroes only link_run_q, the lane masks and the hold outputs.
    always @(posedge aclk) begin
        if (!aresetn) begin
            link_run_q <= 1'b0;
            lane_enable_a_q <= 8'h00;
            lane_enable_b_q <= 8'h00;
            sync_request_q <= 1'b0;
            marker_pin_receive_enable_q <= 1'b0;
            sample_format_q <= 1'b1;
            scramble_active_q <= 1'b1;
            pattern_select_q <= `SLCR_T_NORMAL;
            hold_low_q <= 1'b0;
            hold_high_q <= 1'b0;
            clock_pattern_q <= 16'h0000;
            ila_id_a_q <= 8'h00;
            ila_id_b_q <= 8'h00;
            link_mode_select_q <= `SLCR_LINK_MODE_RST;
        end else if (clk_en) begin
            // Serializers off and link held while disabled.
            link_run_q <= link_enable_reg_q[0];
            link_mode_select_q <= link_mode_reg_q;
            // Mode eight lanes or fewer is the caller's duty.
            if (!link_enable_reg_q[0]) begin
                lane_enable_a_q <= 8'h00;
                lane_enable_b_q <= 8'h00;
            end else if (upper_lanes) begin
                lane_enable_a_q <= `SLCR_LANES_UPPER;
                lane_enable_b_q <= `SLCR_LANES_UPPER;
            end else begin
                lane_enable_a_q <= `SLCR_LANES_LOWER;
                lane_enable_b_q <= `SLCR_LANES_LOWER;
            end
            // Software request always counts; pins only per source. Active high request out.
            case (sync_source)
                `SLCR_SYNC_SE: sync_request_q <= !se_sync2_q || !soft_sync_reg_q[0];
                `SLCR_SYNC_MARKER: sync_request_q <= !mk_sync2_q || !soft_sync_reg_q[0];
                `SLCR_SYNC_SOFT: sync_request_q <= !soft_sync_reg_q[0];
                default: sync_request_q <= !soft_sync_reg_q[0];
            endcase
            marker_pin_receive_enable_q <= (sync_source == `SLCR_SYNC_MARKER);
            // Format and scrambler trail the register by one cycle; software changes them only with the link off.
            sample_format_q <= link_control_q[`SLCR_BIT_FMT];
            scramble_active_q <= link_is_64b66b || link_control_q[`SLCR_BIT_SCR];
            // Test patterns; 8b/10b-only codes pass through since software owns that check.
            case (test_code)
                `SLCR_T_NORMAL, `SLCR_T_PRBS7, `SLCR_T_PRBS15, `SLCR_T_PRBS23,
                `SLCR_T_PRBS9, `SLCR_T_PRBS31: pattern_select_q <= test_code;
                `SLCR_T_RAMP, `SLCR_T_TRANSPORT, `SLCR_T_D215: pattern_select_q <= test_code;
                `SLCR_T_K285, `SLCR_T_ILA, `SLCR_T_RPAT, `SLCR_T_K287: pattern_select_q <= test_code;
                `SLCR_T_LOW, `SLCR_T_HIGH, `SLCR_T_CLOCK: pattern_select_q <= test_code;
                default: pattern_select_q <= `SLCR_T_NORMAL;
            endcase
            hold_low_q <= link_enable_reg_q[0] && (test_code == `SLCR_T_LOW);
            hold_high_q <= link_enable_reg_q[0] && (test_code == `SLCR_T_HIGH);
            clock_pattern_q <= (test_code == `SLCR_T_CLOCK) ? `SLCR_CLOCK_PATTERN : 16'h0000;
            // Identifiers for the second ILA multiframe; bit 0 is always clear so +1 never carries.
            ila_id_a_q <= link_identifier_q;
            ila_id_b_q <= link_identifier_q | 8'h01;
        end
    end
endmodule

// >>> slcr_sva.sv
// Port-level assertions for the serial link control register bank.
module slcr_sva (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire link_is_64b66b,
    input wire link_run_q,
    input wire [7:0] lane_enable_a_q,
    input wire [7:0] lane_enable_b_q,
    input wire scramble_active_q,
    input wire [4:0] pattern_select_q,
    input wire hold_low_q,
    input wire hold_high_q,
    input wire [15:0] clock_pattern_q,
    input wire [7:0] ila_id_a_q,
    input wire [7:0] ila_id_b_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain; the lane map check waits two edges and the lane-off check one; the masks load on the same edge as link_run_q.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_lane_map: assert property (link_run_q && $past(link_run_q) && $past(link_run_q, 2)
        |-> lane_enable_a_q == lane_enable_b_q && (lane_enable_a_q == 8'h0F || lane_enable_a_q == 8'hF0))
        else $error("lane mask wrong");
    chk_lane_off: assert property (!link_run_q && !$past(link_run_q) |-> lane_enable_a_q == 8'h00
        && lane_enable_b_q == 8'h00) else $error("lanes on while disabled");
    chk_id_pair: assert property ($past(aresetn) |-> !ila_id_a_q[0] && ila_id_b_q == ila_id_a_q + 8'h01)
        else $error("identifier pair wrong");
    chk_clock_pat: assert property (clock_pattern_q == (pattern_select_q == 5'h0F ? 16'h00FF : 16'h0000))
        else $error("clock pattern wrong");
    chk_hold_low: assert property (hold_low_q |-> pattern_select_q == 5'h0A && link_run_q)
        else $error("hold low wrong");
    chk_hold_high: assert property (hold_high_q |-> pattern_select_q == 5'h0B && link_run_q)
        else $error("hold high wrong");
    chk_scr_wide: assert property (link_is_64b66b |=> scramble_active_q)
        else $error("wide coding not scrambled");
    // Both halves are latched at the handshake, the write lands one edge later and raises the response.
    chk_b_after: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_after: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

// >>> slcr_rx_model.sv
// Behavioural far-end receiver driving the sync request pins and the coding level.
module slcr_rx_model (
    input wire aclk,
    input wire want_se,
    input wire want_mk,
    input wire enc64,
    output logic single_ended_sync_pin,
    output logic marker_input_pin,
    output logic link_is_64b66b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Requests are active low, so the idle lines sit high from time zero.
    initial begin
        single_ended_sync_pin = 1'b1;
        marker_input_pin = 1'b1;
        link_is_64b66b = 1'b0;
    end
    // Lines change just after the edge, unrelated to when the bank is written.
    always @(posedge aclk) begin
        single_ended_sync_pin <= !want_se;
        marker_input_pin <= !want_mk;
        link_is_64b66b <= enc64;
    end
endmodule

// >>> tb_top.sv
// Self-checking bench for the serial link control register bank.
`include "slcr_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, clk_en, want_se, want_mk, enc64, se_pin, mk_pin, is64;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, link_run_q, sync_request_q;
    logic marker_pin_receive_enable_q, sample_format_q, scramble_active_q, hold_low_q, hold_high_q;
    logic [7:0] lane_enable_a_q, lane_enable_b_q, ila_id_a_q, ila_id_b_q, link_mode_select_q;
    logic [4:0] pattern_select_q;
    logic [15:0] clock_pattern_q;
    int failures, checks_done, seed, i, tc, m[7];
    slcr_serial_link_control_regs #(.ADDR_W(12)) dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .single_ended_sync_pin(se_pin), .marker_input_pin(mk_pin), .link_is_64b66b(is64),
        .link_run_q, .lane_enable_a_q, .lane_enable_b_q, .sync_request_q, .marker_pin_receive_enable_q,
        .sample_format_q, .scramble_active_q, .pattern_select_q, .hold_low_q, .hold_high_q, .clock_pattern_q,
        .ila_id_a_q, .ila_id_b_q, .link_mode_select_q);
    slcr_rx_model rx (.aclk, .want_se, .want_mk, .enc64, .single_ended_sync_pin(se_pin),
        .marker_input_pin(mk_pin), .link_is_64b66b(is64));
    // Free-running 25 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Ends the run; both the main sequence and the watchdog come here.
    task automatic wrap_up();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Responses are taken after a random pause so the slave must hold them.
    task automatic axw(input logic [11:0] a, input logic [31:0] dw, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dw;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        repeat ($random(seed) & 1) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        repeat ($random(seed) & 1) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Register model: each register owns the low byte of the word at four times its index.
    // Unmapped indices answer with an error and hold nothing.
    task automatic wr(input int x, input int dw, input int s);
        int k;
        k = x - `SLCR_LINK_ENABLE_OFF;
        axw(12'(4 * x), dw, s[3:0]);
        `CHK(resp, (k < 0 || k > 6 || k == 2) ? `SLCR_RESP_SLVERR : `SLCR_RESP_OKAY)
        if (s[0] && k >= 0 && k <= 6 && k != 2)
            m[k] = dw & (k == 6 ? 'hFE : k > 3 ? 'h1F : 'hFF);
    endtask
    task automatic rd(input int x);
        int k;
        k = x - `SLCR_LINK_ENABLE_OFF;
        axr(12'(4 * x));
        `CHK(rd_q, (k < 0 || k > 6 || k == 2) ? 0 : m[k])
        `CHK(resp, (k < 0 || k > 6 || k == 2) ? `SLCR_RESP_SLVERR : `SLCR_RESP_OKAY)
    endtask
    // Pins pass a two-flop synchroniser, so the settle wait covers three edges and more.
    task automatic chk_out();
        int c, t, src, on;
        repeat (5) @(posedge aclk);
        c = m[4];
        t = m[5];
        src = (c >> 2) & 3;
        on = m[0] & 1;
        `CHK(link_run_q, on[0])
        `CHK(lane_enable_a_q, on ? ((c & 16) ? 8'hF0 : 8'h0F) : 8'h00)
        `CHK(lane_enable_b_q, on ? ((c & 16) ? 8'hF0 : 8'h0F) : 8'h00)
        `CHK(sample_format_q, c[1])
        `CHK(scramble_active_q, c[0] | is64)
        `CHK(pattern_select_q, (t == 12 || t > 16) ? 5'h00 : t[4:0])
        `CHK(hold_low_q, on[0] && t == 10)
        `CHK(hold_high_q, on[0] && t == 11)
        `CHK(clock_pattern_q, t == 15 ? 16'h00FF : 16'h0000)
        `CHK(ila_id_a_q, m[6][7:0])
        `CHK(ila_id_b_q, m[6][7:0] + 8'h01)
        `CHK(marker_pin_receive_enable_q, src == 1)
        `CHK(link_mode_select_q, m[1][7:0])
        `CHK(sync_request_q, !m[3][0] || (src == 0 && want_se) || (src == 1 && want_mk))
    endtask
    // Watchdog sized well above the full sequence.
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        wrap_up();
    end
    // Main sequence: reset values, unmapped place, random programming, then every test code.
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {want_se, want_mk, enc64, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        clk_en = 1'b1;
        seed = 72782;
        m = '{1, 2, 0, 1, 3, 0, 0};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++)
            rd(`SLCR_LINK_ENABLE_OFF + i);
        chk_out();
        wr('h100, -1, 'hF);
        rd('h100);
        wr(`SLCR_LINK_ENABLE_OFF + 2, -1, 'hF);
        rd(`SLCR_LINK_ENABLE_OFF + 2);
        // Settings change only while the link is off; the mode stays at its narrow reset value.
        for (i = 0; i < 12; i++) begin
            wr(`SLCR_LINK_ENABLE_OFF, 0, 1);
            want_se <= $random(seed);
            want_mk <= $random(seed);
            enc64 <= $random(seed);
            wr(`SLCR_LINK_CONTROL_OFF, $random(seed), 1);
            tc = $random(seed) & 31;
            if (enc64 && (tc == 7 || tc == 8 || tc == 9 || tc == 16))
                tc = 0;
            wr(`SLCR_LINK_TEST_OFF, tc, 1);
            wr(`SLCR_LINK_ID_OFF, $random(seed), 1);
            wr(`SLCR_SOFT_SYNC_OFF, $random(seed), 1);
            chk_out();
            wr(`SLCR_LINK_ENABLE_OFF, 1, 1);
            for (tc = 3; tc < 7; tc++)
                rd(`SLCR_LINK_ENABLE_OFF + tc);
            chk_out();
        end
        enc64 <= 1'b0;
        for (i = 0; i < 32; i++) begin
            wr(`SLCR_LINK_ENABLE_OFF, 0, 1);
            wr(`SLCR_LINK_TEST_OFF, i, 1);
            wr(`SLCR_LINK_ENABLE_OFF, 1, 1);
            chk_out();
        end
        wrap_up();
    end
endmodule
bind slcr_serial_link_control_regs slcr_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .link_is_64b66b, .link_run_q, .lane_enable_a_q,
    .lane_enable_b_q, .scramble_active_q, .pattern_select_q, .hold_low_q, .hold_high_q, .clock_pattern_q,
    .ila_id_a_q, .ila_id_b_q);
